/* common/icr_regs.vh */
// Constants for the interrupt CPU interface control register bank.
// Assumes inclusion by the bank and its encoding decoder only.
`ifndef ICR_REGS_VH
`define ICR_REGS_VH

// =============================================================
// System-register coordinates
`define ICR_OP0_GIC 2'h3
`define ICR_CRN_GIC 4'hC
`define ICR_OP1_EL1 3'h0
`define ICR_OP1_EL2 3'h4
`define ICR_OP1_EL3 3'h6
`define ICR_CRM_CTLR 4'hC
`define ICR_CRM_AP0 4'h8
`define ICR_CRM_AP1 4'h9
`define ICR_CRM_VTR 4'hB
`define ICR_OP2_CTLR 3'h4
`define ICR_OP2_AP0 3'h4
`define ICR_OP2_AP1 3'h0
`define ICR_OP2_VTR 3'h1

// =============================================================
// One-hot register select positions
`define ICR_SEL_CTLR1 0
`define ICR_SEL_VCTLR 1
`define ICR_SEL_AP0 2
`define ICR_SEL_VAP0 3
`define ICR_SEL_AP1 4
`define ICR_SEL_VAP1 5
`define ICR_SEL_VTR 6
`define ICR_SEL_CTLR3 7
`define ICR_SEL_W 8

// =============================================================
// Control register field positions
`define ICR_BIT_EXT_RANGE 19
`define ICR_BIT_RSS 18
`define ICR_BIT_A3V 15
`define ICR_BIT_LOCAL_ERROR_IRQ_SUPPORT 14
`define ICR_ID_W_HI 13
`define ICR_ID_W_LO 11
`define ICR_PRI_W_HI 10
`define ICR_PRI_W_LO 8
`define ICR_BIT_PMHE 6
`define ICR_BIT_EOI 1

// =============================================================
// Read-only field values and reset values
`define ICR_EXT_RANGE_VAL 1'h1
`define ICR_RSS_VAL 1'h0
`define ICR_A3V_VAL 1'h1
`define ICR_LOCAL_ERROR_IRQ_SUPPORT_VAL 1'h0
`define ICR_ID_W_VAL 3'h0
`define ICR_PRI_W_VAL 3'h4
`define ICR_PRI_BITS_MIN_2SEC 3'h5
`define ICR_PRI_BITS_MIN_1SEC 3'h4
`define ICR_BPR_MAX 3'h7
`define ICR_EXT_ID_LO 16'h0400
`define ICR_EXT_ID_HI 16'h1FFF
`define ICR_PMHE_RST 1'h0
`define ICR_EOI_RST 1'h0
`define ICR_AP_RST 32'h0
`define ICR_VTR_VAL 64'h0000_0000_9000_0000

`endif

/* rtl/icr_decode.v */
// Encoding decoder: turns a system-register coordinate into a one-hot select.
// Assumes the coordinate is held stable while the request is valid.
`timescale 1ns/1ps
`include "icr_regs.vh"

module icr_decode (
  input wire [1:0] op0,
  input wire [3:0] crn,
  input wire [2:0] op1,
  input wire [3:0] crm,
  input wire [2:0] op2,
  input wire use_virtual,
  output reg [`ICR_SEL_W-1:0] sel
);

  wire base_ok;
  wire shared_ctlr;
  wire shared_ap0;
  wire shared_ap1;

  assign base_ok = (op0 == `ICR_OP0_GIC) && (crn == `ICR_CRN_GIC);
  assign shared_ctlr = base_ok && (op1 == `ICR_OP1_EL1) && (crm == `ICR_CRM_CTLR) &&
                       (op2 == `ICR_OP2_CTLR); // R1
  assign shared_ap0 = base_ok && (op1 == `ICR_OP1_EL1) && (crm == `ICR_CRM_AP0) &&
                      (op2 == `ICR_OP2_AP0); // R2
  assign shared_ap1 = base_ok && (op1 == `ICR_OP1_EL1) && (crm == `ICR_CRM_AP1) &&
                      (op2 == `ICR_OP2_AP1); // R3

  // Shared encodings are steered by the virtualisation state of the requester.
  always @* begin
    sel = {`ICR_SEL_W{1'b0}};
    sel[`ICR_SEL_CTLR1] = shared_ctlr && !use_virtual; // R19
    sel[`ICR_SEL_VCTLR] = shared_ctlr && use_virtual; // R19
    sel[`ICR_SEL_AP0] = shared_ap0 && !use_virtual;
    sel[`ICR_SEL_VAP0] = shared_ap0 && use_virtual;
    sel[`ICR_SEL_AP1] = shared_ap1 && !use_virtual;
    sel[`ICR_SEL_VAP1] = shared_ap1 && use_virtual;
    sel[`ICR_SEL_VTR] = base_ok && (op1 == `ICR_OP1_EL2) && (crm == `ICR_CRM_VTR) &&
                        (op2 == `ICR_OP2_VTR); // R4
    sel[`ICR_SEL_CTLR3] = base_ok && (op1 == `ICR_OP1_EL3) && (crm == `ICR_CRM_CTLR) &&
                          (op2 == `ICR_OP2_CTLR); // R5
  end

endmodule // icr_decode

/* rtl/icr_bank.v */
// System-register bank of the interrupt controller CPU interface.
// Assumes the core pipeline issues one access per valid cycle in the mclk domain.
//
// Functional notes
// R1 - Physical and virtual EL1 control decode at 3/C12/0/C12/4, 64 bits.
// R2 - Group 0 active priorities, physical and virtual, decode at 3/C12/0/C8/4.
// R3 - Group 1 active priorities, physical and virtual, decode at 3/C12/0/C9/0.
// R4 - Virtual interface type decodes at 3/C12/4/C11/1, 64 bits wide.
// R5 - EL3 control register decodes at 3/C12/6/C12/4, 64 bits wide.
// R6 - Control bit 19 reads one: identifiers 1024 to 8191 supported.
// R7 - Identifiers 1024 to 8191 always need an explicit deactivation.
// R8 - Control bit 18 reads zero: targeted affinity 0 values 0 to 15 only.
// R9 - Control bit 15 reads one, ignores writes: non-zero affinity 3 allowed.
// R10 - Control bit 14 reads zero, ignores writes: no local error interrupts.
// R11 - Control bits 13:11 read 000, sixteen identifier bits, writes ignored.
// R12 - Control bits 10:8 read priority bits minus one, value 100, read-only.
// R13 - Two security states need at least five priority bits.
// R14 - One security state needs at least four priority bits.
// R15 - Priority width reads the same for any security state or setting.
// R16 - Physical priority width sets the group 0 binary point minimum.
// R17 - With EL3 present, EL1 priority width reads the EL3 field.
// R18 - Control bits 63:20 and 17:16 read zero, writes have no effect.
// R19 - Shared encodings reach virtual registers when virtual handling applies.
`timescale 1ns/1ps
`include "icr_regs.vh"

module icr_bank (
  input wire mclk,
  input wire rst_n,
  input wire req_valid,
  input wire req_write,
  input wire [1:0] req_op0,
  input wire [3:0] req_crn,
  input wire [2:0] req_op1,
  input wire [3:0] req_crm,
  input wire [2:0] req_op2,
  input wire [63:0] req_wdata,
  input wire req_virtual,
  input wire req_secure,
  input wire el3_present,
  input wire distributor_disable_security,
  input wire [15:0] query_interrupt_identifier,
  output wire rsp_valid,
  output wire rsp_error,
  output wire [63:0] rsp_rdata,
  output wire query_needs_deactivation,
  output wire [2:0] group0_binary_point_min,
  output wire eoi_split_physical,
  output wire eoi_split_virtual,
  output wire priority_mask_hint
);

  // ===========================================================
  // Decode
  wire [`ICR_SEL_W-1:0] sel;
  wire hit;
  wire wr;

  icr_decode u_decode (
    .op0(req_op0),
    .crn(req_crn),
    .op1(req_op1),
    .crm(req_crm),
    .op2(req_op2),
    .use_virtual(req_virtual),
    .sel(sel)
  );

  assign hit = |sel;
  assign wr = req_valid && req_write;

  // ===========================================================
  // Storage
  reg rsp_valid_ff;
  reg rsp_error_ff;
  reg [63:0] rsp_rdata_ff;
  reg deact_ff;
  reg [2:0] bpr_min_ff;
  reg pmhe_ff;
  reg eoi_el1_ff;
  reg eoi_virt_ff;
  reg [31:0] ap0_ff;
  reg [31:0] vap0_ff;
  reg [31:0] ap1_ff;
  reg [31:0] vap1_ff;

  // ===========================================================
  // Read values
  // The priority width is a constant of the build, so neither the security state of
  // the access nor the distributor setting can change what is returned.
  wire [2:0] pri_w_el3;
  wire [2:0] pri_w_el1;
  wire [63:0] ctlr_ro;
  wire [63:0] ctlr1_val;
  wire [63:0] vctlr_val;
  wire [63:0] ctlr3_val;
  wire unused_secure;

  assign unused_secure = req_secure;
  assign pri_w_el3 = `ICR_PRI_W_VAL; // R12 R15
  assign pri_w_el1 = el3_present ? pri_w_el3 : `ICR_PRI_W_VAL; // R17 R15

  function [63:0] ctlr_fields;
    input [2:0] pri_w;
    reg [63:0] v;
    begin
      v = 64'h0; // R18
      v[`ICR_BIT_EXT_RANGE] = `ICR_EXT_RANGE_VAL; // R6
      v[`ICR_BIT_RSS] = `ICR_RSS_VAL; // R8
      v[`ICR_BIT_A3V] = `ICR_A3V_VAL; // R9
      v[`ICR_BIT_LOCAL_ERROR_IRQ_SUPPORT] = `ICR_LOCAL_ERROR_IRQ_SUPPORT_VAL; // R10
      v[`ICR_ID_W_HI:`ICR_ID_W_LO] = `ICR_ID_W_VAL; // R11
      v[`ICR_PRI_W_HI:`ICR_PRI_W_LO] = pri_w; // R12
      ctlr_fields = v;
    end
  endfunction

  assign ctlr_ro = ctlr_fields(pri_w_el1);
  assign ctlr1_val = ctlr_ro | ({63'h0, pmhe_ff} << `ICR_BIT_PMHE) |
                     ({63'h0, eoi_el1_ff} << `ICR_BIT_EOI);
  assign vctlr_val = ctlr_ro | ({63'h0, eoi_virt_ff} << `ICR_BIT_EOI);
  assign ctlr3_val = ctlr_fields(pri_w_el3) | ({63'h0, pmhe_ff} << `ICR_BIT_PMHE);

  reg [63:0] nxt_rdata;
  always @* begin
    nxt_rdata = 64'h0;
    case (1'b1)
      sel[`ICR_SEL_CTLR1]: nxt_rdata = ctlr1_val;
      sel[`ICR_SEL_VCTLR]: nxt_rdata = vctlr_val;
      sel[`ICR_SEL_AP0]: nxt_rdata = {32'h0, ap0_ff};
      sel[`ICR_SEL_VAP0]: nxt_rdata = {32'h0, vap0_ff};
      sel[`ICR_SEL_AP1]: nxt_rdata = {32'h0, ap1_ff};
      sel[`ICR_SEL_VAP1]: nxt_rdata = {32'h0, vap1_ff};
      sel[`ICR_SEL_VTR]: nxt_rdata = `ICR_VTR_VAL;
      sel[`ICR_SEL_CTLR3]: nxt_rdata = ctlr3_val;
      default: nxt_rdata = 64'h0;
    endcase
  end

  // ===========================================================
  // Response path
  // An unmapped coordinate or a write to the read-only type register is answered
  // with an error and zero data, so the pipeline can raise its own trap.
  wire nxt_error;
  assign nxt_error = !hit || (req_write && sel[`ICR_SEL_VTR]);

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid_ff <= 1'b0;
      rsp_error_ff <= 1'b0;
      rsp_rdata_ff <= 64'h0;
    end else begin
      rsp_valid_ff <= req_valid;
      rsp_error_ff <= req_valid && nxt_error;
      if (req_valid && !req_write && !nxt_error) begin
        rsp_rdata_ff <= nxt_rdata;
      end else begin
        rsp_rdata_ff <= 64'h0;
      end
    end
  end

  // ===========================================================
  // Writable control bits
  // The hint enable is one flop shared by the EL1 and EL3 control registers; from EL1, with EL3
  // present, it can only be written when the distributor has security disabled.
  wire pmhe_wr_el1;
  assign pmhe_wr_el1 = wr && sel[`ICR_SEL_CTLR1] && distributor_disable_security;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pmhe_ff <= `ICR_PMHE_RST;
      eoi_el1_ff <= `ICR_EOI_RST;
      eoi_virt_ff <= `ICR_EOI_RST;
    end else begin
      if (wr && sel[`ICR_SEL_CTLR3]) begin
        pmhe_ff <= req_wdata[`ICR_BIT_PMHE];
      end else if (pmhe_wr_el1 && el3_present) begin
        pmhe_ff <= req_wdata[`ICR_BIT_PMHE];
      end else if (wr && sel[`ICR_SEL_CTLR1] && !el3_present) begin
        pmhe_ff <= req_wdata[`ICR_BIT_PMHE];
      end
      if (wr && sel[`ICR_SEL_CTLR1]) begin
        eoi_el1_ff <= req_wdata[`ICR_BIT_EOI];
      end
      if (wr && sel[`ICR_SEL_VCTLR]) begin
        eoi_virt_ff <= req_wdata[`ICR_BIT_EOI];
      end
    end
  end

  // ===========================================================
  // Active priorities, physical and virtual
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ap0_ff <= `ICR_AP_RST;
      vap0_ff <= `ICR_AP_RST;
      ap1_ff <= `ICR_AP_RST;
      vap1_ff <= `ICR_AP_RST;
    end else if (wr) begin
      if (sel[`ICR_SEL_AP0]) begin
        ap0_ff <= req_wdata[31:0]; // R2
      end
      if (sel[`ICR_SEL_VAP0]) begin
        vap0_ff <= req_wdata[31:0]; // R2
      end
      if (sel[`ICR_SEL_AP1]) begin
        ap1_ff <= req_wdata[31:0]; // R3
      end
      if (sel[`ICR_SEL_VAP1]) begin
        vap1_ff <= req_wdata[31:0]; // R3
      end
    end
  end

  // ===========================================================
  // Derived status
  // Five implemented priority bits satisfy both the two-state minimum and the
  // single-state minimum, so no build option is needed for either case.
  wire [2:0] pri_bits;
  wire [2:0] nxt_bpr_min;
  wire nxt_deact;

  assign pri_bits = pri_w_el3 + 3'h1;
  assign nxt_bpr_min = (pri_bits >= `ICR_PRI_BITS_MIN_2SEC) ?
                       (`ICR_BPR_MAX - pri_bits) : // R13 R16
                       (`ICR_BPR_MAX - `ICR_PRI_BITS_MIN_1SEC); // R14
  assign nxt_deact = (query_interrupt_identifier >= `ICR_EXT_ID_LO) &&
                     (query_interrupt_identifier <= `ICR_EXT_ID_HI); // R7

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      deact_ff <= 1'b0;
      bpr_min_ff <= 3'h0;
    end else begin
      deact_ff <= nxt_deact; // R7
      bpr_min_ff <= nxt_bpr_min; // R16
    end
  end

  // ===========================================================
  // Outputs
  assign rsp_valid = rsp_valid_ff;
  assign rsp_error = rsp_error_ff;
  assign rsp_rdata = rsp_rdata_ff;
  assign query_needs_deactivation = deact_ff;
  assign group0_binary_point_min = bpr_min_ff;
  assign eoi_split_physical = eoi_el1_ff;
  assign eoi_split_virtual = eoi_virt_ff;
  assign priority_mask_hint = pmhe_ff;

endmodule // icr_bank

/* test/icr_bank_sva.sv */
// Checker of the CPU interface register bank, watching its ports only.
// Assumes one clock domain and the bind below.
`timescale 1ns/1ps
module icr_bank_sva (
  input wire mclk,
  input wire rst_n,
  input wire req_valid,
  input wire req_write,
  input wire [1:0] req_op0,
  input wire [3:0] req_crn,
  input wire [2:0] req_op1,
  input wire [3:0] req_crm,
  input wire [2:0] req_op2,
  input wire req_virtual,
  input wire [15:0] query_interrupt_identifier,
  input wire rsp_valid,
  input wire rsp_error,
  input wire [63:0] rsp_rdata,
  input wire query_needs_deactivation,
  input wire [2:0] group0_binary_point_min
);
  // ==========
  // Properties
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  wire [15:0] crd = {req_op0, req_crn, req_op1, req_crm, req_op2};
  wire [15:0] qid = query_interrupt_identifier;
  wire rd_ctl = req_valid && !req_write && !req_virtual && crd == 16'hF064;
  wire in_ext = qid >= 16'h0400 && qid <= 16'h1FFF;
  AST_RSP_NEXT: assert property (req_valid |=> rsp_valid)
    else $error("no response one cycle after a request");
  AST_RSP_ONLY: assert property (!req_valid |=> !rsp_valid)
    else $error("response without a request");
  AST_CTL_OK: assert property (req_valid && crd == 16'hF064 |=> !rsp_error)
    else $error("control encoding refused");
  AST_EXT_RANGE: assert property (rd_ctl |=> rsp_rdata[19] && !rsp_rdata[18])
    else $error("range fields wrong");
  AST_A3V_LOCAL_ERROR_IRQ_SUPPORT: assert property (rd_ctl |=> rsp_rdata[15:14] == 2'h2)
    else $error("affinity or error support field wrong");
  AST_ID_PRI_W: assert property (rd_ctl |=> rsp_rdata[13:8] == 6'h04)
    else $error("width fields wrong");
  AST_RESV: assert property (rd_ctl |=> rsp_rdata[63:20] == 44'h0 && rsp_rdata[17:16] == 2'h0)
    else $error("reserved control bits not zero");
  AST_QUERY: assert property ($past(rst_n) |-> query_needs_deactivation == $past(in_ext))
    else $error("deactivation class wrong");
  AST_BPR_MIN: assert property ($past(rst_n) |-> group0_binary_point_min == 3'h2)
    else $error("binary point minimum wrong");
  AST_AP_OK: assert property (req_valid && (crd == 16'hF044 || crd == 16'hF048) |=> !rsp_error)
    else $error("active priority encoding refused");
  AST_TYPE_WR: assert property (req_valid && req_write && crd == 16'hF259 |=> rsp_error)
    else $error("type register write accepted");
  AST_EL3_OK: assert property (req_valid && crd == 16'hF364 |=> !rsp_error)
    else $error("top level control encoding refused");
  cover property (rd_ctl);
  cover property (req_valid ##1 req_valid);
  cover property (query_needs_deactivation);
endmodule // icr_bank_sva

bind icr_bank icr_bank_sva i_sva (.mclk, .rst_n, .req_valid, .req_write, .req_op0, .req_crn,
  .req_op1, .req_crm, .req_op2, .req_virtual, .query_interrupt_identifier, .rsp_valid,
  .rsp_error, .rsp_rdata, .query_needs_deactivation, .group0_binary_point_min);

/* test/icr_core_model.sv */
// Model of the core pipeline issuing system-register accesses.
// Assumes a one-cycle answer; requests change only after a rising edge.
`timescale 1ns/1ps
module icr_core_model (
  input wire mclk,
  output logic req_valid,
  output logic req_write,
  output logic [15:0] req_crd,
  output logic [63:0] req_wdata,
  output logic req_virtual,
  input wire rsp_error,
  input wire [63:0] rsp_rdata
);
  // ==========
  // Request tasks
  initial begin
    {req_valid, req_write, req_crd, req_wdata, req_virtual} = 83'h0;
  end
  task automatic put(input logic w, input logic [15:0] c, input logic [63:0] d, input logic v);
    req_valid <= 1'b1;
    req_write <= w;
    req_crd <= c;
    req_wdata <= d;
    req_virtual <= v;
  endtask
  // Released coordinate and write data show the inverse so a design that samples late is caught.
  task automatic drop(input logic [15:0] c, input logic [63:0] d);
    req_valid <= 1'b0;
    req_crd <= ~c;
    req_wdata <= ~d;
  endtask
  task automatic access(input logic w, input logic [15:0] c, input logic [63:0] d,
                        input logic v, output logic e, output logic [63:0] q);
    @(posedge mclk);
    put(w, c, d, v);
    @(posedge mclk);
    drop(c, d);
    @(posedge mclk);
    e = rsp_error;
    q = rsp_rdata;
  endtask
  task automatic wr_rd(input logic [15:0] c, input logic [63:0] d, input logic v,
                       output logic [63:0] q);
    @(posedge mclk);
    put(1'b1, c, d, v);
    @(posedge mclk);
    put(1'b0, c, d, v);
    @(posedge mclk);
    drop(c, d);
    @(posedge mclk);
    q = rsp_rdata;
  endtask
endmodule // icr_core_model

/* test/tb_top.sv */
// Self-checking bench of the interrupt CPU interface register bank.
// Assumes the core model drives the register port.
`timescale 1ns/1ps
module tb_top;
  localparam logic [15:0] CTL = 16'hF064;
  localparam logic [15:0] EL3C = 16'hF364;
  localparam logic [15:0] VTR = 16'hF259;
  logic mclk, rst_n, req_secure, el3_present, dds, e;
  logic [15:0] qid;
  logic [63:0] q;
  wire rq_v, rq_w, rq_virt, rs_v, rs_e, qnd, eoi_p, eoi_v, pmh;
  wire [15:0] crd;
  wire [2:0] bpr;
  wire [63:0] wd, rd;
  int fails = 0;
  int n_tests = 0;
  icr_core_model i_core (.mclk(mclk), .req_valid(rq_v), .req_write(rq_w), .req_crd(crd),
    .req_wdata(wd), .req_virtual(rq_virt), .rsp_error(rs_e), .rsp_rdata(rd));
  icr_bank i_dut (.mclk(mclk), .rst_n(rst_n), .req_valid(rq_v), .req_write(rq_w),
    .req_op0(crd[15:14]), .req_crn(crd[13:10]), .req_op1(crd[9:7]), .req_crm(crd[6:3]),
    .req_op2(crd[2:0]), .req_wdata(wd), .req_virtual(rq_virt), .req_secure(req_secure),
    .el3_present(el3_present), .distributor_disable_security(dds),
    .query_interrupt_identifier(qid), .rsp_valid(rs_v), .rsp_error(rs_e), .rsp_rdata(rd),
    .query_needs_deactivation(qnd), .group0_binary_point_min(bpr),
    .eoi_split_physical(eoi_p), .eoi_split_virtual(eoi_v), .priority_mask_hint(pmh));
  // ==========
  // Checking and verdict
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========
  // Scenarios
  task automatic t_ctlr;
    for (int i = 0; i < 4; i++) begin
      req_secure <= i[0];
      dds <= i[1];
      i_core.access(1'b0, CTL, 64'h0, 1'b0, e, q);
      chk("ctlr_rd", 64'h0000_0000_0008_8400, q);
    end
    i_core.access(1'b0, EL3C, 64'h0, 1'b0, e, q);
    chk("el3_pri_w", 64'h4, {61'h0, q[10:8]});
    // Without the top level the hint bit is writable from below.
    el3_present <= 1'b0;
    i_core.access(1'b1, CTL, {64{1'b1}}, 1'b0, e, q);
    i_core.access(1'b0, CTL, 64'h0, 1'b0, e, q);
    chk("ctlr_wr", 64'h0000_0000_0008_8442, q);
    i_core.access(1'b0, CTL, 64'h0, 1'b1, e, q);
    chk("vctlr_eoi", 64'h0, {63'h0, q[1]});
    i_core.access(1'b1, CTL, 64'h2, 1'b1, e, q);
    chk("eoi_split", 64'h3, {62'h0, eoi_v, eoi_p});
    $display("test ctlr done");
  endtask
  task automatic t_ap;
    logic [15:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[1] ? 16'hF048 : 16'hF044;
      i_core.wr_rd(c, 64'hFFFF_FFFF_C3C3_0000 | i, i[0], q);
      chk("ap_b2b", 64'hC3C3_0000 | i, q);
    end
    for (int i = 0; i < 4; i++) begin
      c = i[1] ? 16'hF048 : 16'hF044;
      i_core.access(1'b0, c, 64'h0, i[0], e, q);
      chk("ap_keep", 64'hC3C3_0000 | i, q);
    end
    $display("test ap done");
  endtask
  task automatic t_misc;
    i_core.access(1'b0, VTR, 64'h0, 1'b0, e, q);
    chk("type_rd", 64'h0, {63'h0, e});
    i_core.access(1'b1, VTR, {64{1'b1}}, 1'b0, e, q);
    chk("type_wr", 64'h1, {63'h0, e});
    i_core.access(1'b0, 16'hB064, 64'h0, 1'b0, e, q);
    chk("unmapped", 64'h1, {63'h0, e});
    chk("unmapped_data", 64'h0, q);
    chk("bpr_min", 64'h2, {61'h0, bpr});
    $display("test misc done");
  endtask
  // With the top level present, the shared hint bit is writable from below only when
  // the distributor has security disabled; the top level register always writes it.
  task automatic t_hint;
    el3_present <= 1'b1;
    dds <= 1'b0;
    i_core.access(1'b1, CTL, 64'h0, 1'b0, e, q);
    chk("hint_locked", 64'h1, {63'h0, pmh});
    chk("eoi_cleared", 64'h0, {63'h0, eoi_p});
    dds <= 1'b1;
    i_core.access(1'b1, CTL, 64'h0, 1'b0, e, q);
    chk("hint_open", 64'h0, {63'h0, pmh});
    i_core.access(1'b1, EL3C, 64'h42, 1'b0, e, q);
    chk("hint_el3", 64'h1, {63'h0, pmh});
    i_core.access(1'b0, EL3C, 64'h0, 1'b0, e, q);
    chk("el3_rd", 64'h0000_0000_0008_8440, q);
    $display("test hint done");
  endtask
  task automatic t_query;
    logic [15:0] ids [4] = '{16'h03FF, 16'h0400, 16'h1FFF, 16'h2000};
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      qid <= ids[i];
      repeat (2) @(posedge mclk);
      chk("query", {63'h0, i == 1 || i == 2}, {63'h0, qnd});
    end
    $display("test query done");
  endtask
  // ==========
  // Clock, reset and sequence
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    rst_n = 1'b0;
    req_secure = 1'b0;
    el3_present = 1'b1;
    dds = 1'b0;
    qid = 16'h0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    t_ctlr();
    t_ap();
    t_misc();
    t_hint();
    t_query();
    give_verdict();
  end
  initial begin
    repeat (2000) @(posedge mclk);
    fails++;
    give_verdict();
  end
endmodule // tb_top
